/* core/hw_config_low.sv */
// hardware configuration low fields: pin polarity/select, packing, eeprom
// time-out, lite and full soft reset sequencer, apb slave, interrupt
// assumes por on rstn; usb reset, state inputs and eeprom pins are synchronous
// Operation
// RQ1: attach pin polarity low/high by bit 8 in hsic mode, active low otherwise
// RQ2: attach pin also driven in detach mode
// RQ3: suspend select code picks asserting suspend levels
// RQ4: suspend pin polarity low/high by bit 5
// RQ5: suspend fields ignore emulation and eeprom presence
// RQ6: packing bit allows many frames per packet
// RQ7: time-out select 30 ms or 1.28 us
// RQ8: eeprom time-out sets command register flag
// RQ9: lite reset bit starts reset, self-clears
// RQ10: lite reset keeps eeprom image and phy
// RQ11: full reset bit starts reset, self-clears
// RQ12: full reset reloads eeprom into configuration
// RQ13: phy disconnected during full reset, reconnected
// RQ14: protected fields survive non-por resets when protected
// RQ15: protection shields fields from all but por
// RQ16: usb/lite reset restores image or zero
// RQ17: attach pin asserts while attempting attach
// RQ18: reserved bit 2 reads zero, ignores writes
`timescale 1ns/100ps
`default_nettype none
module hw_config_low
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device state
    input wire logic usbReset,
    input wire logic resetProtect,
    input wire logic hsicMode,
    input wire logic attachEnable,
    input wire logic attachAttempt,
    input wire logic network_cable_detach_mode,
    input wire logic [3:0] suspendLevel,
    input wire logic eepromPresent,
    // eeprom controller handshake
    input wire logic eepromAck,
    input wire logic [7:0] eepromData,
    output logic eepromReq,
    // pins and control outputs
    output logic attachPin,
    output logic suspendPin,
    output logic multiFramePack,
    output logic phyDisconnect,
    output logic liteResetOut,
    output logic irq
);
    import hw_config_pkg::*;

    localparam int TO_W = 22;

    // configuration fields
    logic attachPol_r, attachPol_nxt;
    logic [1:0] suspSel_r, suspSel_nxt;
    logic suspPol_r, suspPol_nxt;
    logic pack_r, pack_nxt;
    logic etc_r, etc_nxt;
    // sequencer
    seq_t seq_r, seq_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [2:0] ld_r, ld_nxt;
    // eeprom time-out
    logic [TO_W-1:0] toCnt_r, toCnt_nxt;
    logic eeBusy_r, eeBusy_nxt;
    logic eeTo_r, eeTo_nxt;
    // interrupts
    logic [2:0] sts_r, sts_nxt;
    logic [2:0] ien_r, ien_nxt;
    // registered outputs
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic attachPin_r, attachPin_nxt;
    logic suspendPin_r, suspendPin_nxt;
    logic irq_r, irq_nxt;
    // image memory
    logic imgWr;
    logic [1:0] imgRdAddr;
    logic [7:0] imgData;

    logic wrAcc, rdAcc;
    logic [2:0] evt;

    // suspend level decode used for the pin
    function automatic logic suspActive(input logic [1:0] sel, input logic [3:0] lvl, input logic det);
        logic a;
        a = 1'b0;
        case (sel)
            2'b00: a = lvl[2];
            2'b01: a = lvl[2] | lvl[1] | det;
            2'b10: a = lvl[2] | lvl[1] | lvl[0] | det;
            default: a = |lvl | det;
        endcase
        return a;
    endfunction

    // polarity helper: active high when pol set
    function automatic logic applyPol(input logic act, input logic pol);
        return pol ? act : ~act;
    endfunction

    assign wrAcc = psel && penable && !pready_r && pwrite;
    assign rdAcc = psel && penable && !pready_r && !pwrite;

    // image holds attach pol, suspend select and suspend pol at word 0
    assign imgRdAddr = 2'h0;
    assign imgWr = (seq_r == SEQ_LOAD) && eepromAck;

    image_mem u_img
    (
        .mclk(mclk),
        .rstn(rstn),
        .wrEn(imgWr),
        .wrAddr(ld_r[1:0]),
        .wrData(eepromData),
        .rdAddr(imgRdAddr),
        .rdData(imgData)
    );

    // configuration fields, software writes and reset restores
    always_comb
    begin
        attachPol_nxt = attachPol_r;
        suspSel_nxt = suspSel_r;
        suspPol_nxt = suspPol_r;
        pack_nxt = pack_r;
        etc_nxt = etc_r;
        if (wrAcc && paddr == OFF_HWCFG)
        begin
            attachPol_nxt = pwdata[POS_ATTACH_POL];
            suspSel_nxt = pwdata[POS_SUSP_SEL +: 2];
            suspPol_nxt = pwdata[POS_SUSP_POL];
            pack_nxt = pwdata[POS_PACK]; // RQ6
            etc_nxt = pwdata[POS_ETC]; // RQ7
        end
        // a usb or lite reset restores the last image unless protected
        if ((usbReset || seq_r == SEQ_LITE) && !resetProtect) // RQ14 RQ15 RQ16
        begin
            attachPol_nxt = imgData[POS_ATTACH_POL - 4];
            suspSel_nxt = imgData[POS_SUSP_SEL - 4 +: 2];
            suspPol_nxt = imgData[POS_SUSP_POL - 4];
        end
        // full reset applies the image, freshly loaded if eeprom present, unless protected
        if (seq_r == SEQ_FULL && cnt_r == FULL_CYC && !resetProtect) // RQ12 RQ15
        begin
            attachPol_nxt = imgData[POS_ATTACH_POL - 4];
            suspSel_nxt = imgData[POS_SUSP_SEL - 4 +: 2];
            suspPol_nxt = imgData[POS_SUSP_POL - 4];
            pack_nxt = 1'b0;
            etc_nxt = 1'b0;
        end
    end

    // reset sequencer; lite path never loads eeprom nor touches the phy
    always_comb
    begin
        seq_nxt = seq_r;
        cnt_nxt = cnt_r;
        ld_nxt = ld_r;
        case (seq_r)
            SEQ_IDLE:
            begin
                cnt_nxt = 8'h00;
                ld_nxt = 3'h0;
                if (wrAcc && paddr == OFF_HWCFG && pwdata[POS_FULL]) // RQ11
                    seq_nxt = eepromPresent ? SEQ_LOAD : SEQ_FULL;
                else if (wrAcc && paddr == OFF_HWCFG && pwdata[POS_LITE]) // RQ9
                    seq_nxt = SEQ_LITE;
            end
            SEQ_LITE:
            begin
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r == LITE_CYC) // RQ10
                    seq_nxt = SEQ_IDLE;
            end
            SEQ_LOAD:
            begin
                if (eepromAck)
                    ld_nxt = ld_r + 3'h1;
                if (eepromAck && ld_r == IMG_WORDS - 3'h1) // RQ12
                    seq_nxt = SEQ_FULL;
            end
            default:
            begin
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r == FULL_CYC)
                    seq_nxt = SEQ_IDLE;
            end
        endcase
    end

    // eeprom response watchdog during image load
    always_comb
    begin
        toCnt_nxt = toCnt_r;
        eeBusy_nxt = eeBusy_r;
        eeTo_nxt = eeTo_r;
        if (seq_r == SEQ_LOAD && !eepromAck)
        begin
            eeBusy_nxt = 1'b1;
            toCnt_nxt = toCnt_r + 1'b1;
        end
        else
        begin
            eeBusy_nxt = 1'b0;
            toCnt_nxt = '0;
        end
        if (wrAcc && paddr == OFF_EEPROM_CMD && pwdata[POS_EE_TO])
            eeTo_nxt = 1'b0;
        // set beats clear when both land together
        if (evt[IRQ_EE_TO]) // RQ8
            eeTo_nxt = 1'b1;
    end

    // time-out event at selected limit
    assign evt[IRQ_EE_TO] = eeBusy_r && !eepromAck &&
        (toCnt_r == (etc_r ? TO_W'(EE_TO_SHORT_CYC) : TO_W'(EE_TO_LONG_CYC))); // RQ7
    assign evt[IRQ_LITE_DONE] = seq_r == SEQ_LITE && cnt_r == LITE_CYC;
    assign evt[IRQ_FULL_DONE] = seq_r == SEQ_FULL && cnt_r == FULL_CYC;

    // interrupt status, enable and level output
    always_comb
    begin
        sts_nxt = sts_r;
        ien_nxt = ien_r;
        if (wrAcc && paddr == OFF_IRQ_CLEAR)
            sts_nxt = sts_r & ~pwdata[2:0];
        if (wrAcc && paddr == OFF_IRQ_ENABLE)
            ien_nxt = pwdata[2:0];
        sts_nxt = sts_nxt | evt;
        irq_nxt = |(sts_r & ien_r);
    end

    // apb answers one cycle after the access phase opens
    always_comb
    begin
        pready_nxt = psel && penable && !pready_r;
        pslverr_nxt = 1'b0;
        prdata_nxt = 32'h0000_0000;
        if (psel && penable && !pready_r)
        begin
            if (paddr == OFF_HWCFG)
            begin
                prdata_nxt[POS_ATTACH_POL] = attachPol_r;
                prdata_nxt[POS_SUSP_SEL +: 2] = suspSel_r;
                prdata_nxt[POS_SUSP_POL] = suspPol_r;
                prdata_nxt[POS_PACK] = pack_r;
                prdata_nxt[POS_ETC] = etc_r;
                prdata_nxt[POS_LITE] = seq_r == SEQ_LITE; // RQ9 RQ18
                prdata_nxt[POS_FULL] = seq_r == SEQ_LOAD || seq_r == SEQ_FULL; // RQ11
            end
            else if (paddr == OFF_IRQ_STATUS)
                prdata_nxt[2:0] = sts_r;
            else if (paddr == OFF_IRQ_ENABLE)
                prdata_nxt[2:0] = ien_r;
            else if (paddr == OFF_IRQ_CLEAR)
                prdata_nxt = 32'h0000_0000;
            else if (paddr == OFF_EEPROM_CMD)
            begin
                prdata_nxt[POS_EE_BUSY] = eeBusy_r;
                prdata_nxt[POS_EE_TO] = eeTo_r;
            end
            else if (paddr == OFF_STATE_IN)
                prdata_nxt[3:0] = suspendLevel;
            else
                pslverr_nxt = 1'b1;
        end
    end

    // pins: suspend decode not gated by emulation or eeprom presence
    always_comb
    begin
        attachPin_nxt = applyPol(attachEnable && (attachAttempt || network_cable_detach_mode),
            hsicMode ? attachPol_r : 1'b0); // RQ1 RQ2 RQ17
        suspendPin_nxt = applyPol(suspActive(suspSel_r, suspendLevel, network_cable_detach_mode),
            suspPol_r); // RQ3 RQ4 RQ5
    end

    // state registers
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            attachPol_r <= 1'b0;
            suspSel_r <= 2'b00;
            suspPol_r <= 1'b0;
            pack_r <= 1'b0;
            etc_r <= 1'b0;
            seq_r <= SEQ_IDLE;
            cnt_r <= 8'h00;
            ld_r <= 3'h0;
            toCnt_r <= '0;
            eeBusy_r <= 1'b0;
            eeTo_r <= 1'b0;
            sts_r <= IRQ_RESET;
            ien_r <= IRQ_RESET;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            attachPin_r <= 1'b1;
            suspendPin_r <= 1'b1;
            irq_r <= 1'b0;
        end
        else
        begin
            attachPol_r <= attachPol_nxt;
            suspSel_r <= suspSel_nxt;
            suspPol_r <= suspPol_nxt;
            pack_r <= pack_nxt;
            etc_r <= etc_nxt;
            seq_r <= seq_nxt;
            cnt_r <= cnt_nxt;
            ld_r <= ld_nxt;
            toCnt_r <= toCnt_nxt;
            eeBusy_r <= eeBusy_nxt;
            eeTo_r <= eeTo_nxt;
            sts_r <= sts_nxt;
            ien_r <= ien_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            attachPin_r <= attachPin_nxt;
            suspendPin_r <= suspendPin_nxt;
            irq_r <= irq_nxt;
        end
    end

    // outputs from flops; eepromReq, phyDisconnect and liteResetOut decoded from seq_r
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign attachPin = attachPin_r;
    assign suspendPin = suspendPin_r;
    assign irq = irq_r;
    assign multiFramePack = pack_r;
    assign eepromReq = seq_r == SEQ_LOAD;
    assign phyDisconnect = seq_r == SEQ_LOAD || seq_r == SEQ_FULL; // RQ13
    assign liteResetOut = seq_r == SEQ_LITE;

    // checks
    a_susp_pin: assert property (@(posedge mclk) disable iff (!rstn) // RQ3
        ##1 suspendPin == applyPol(suspActive($past(suspSel_r), $past(suspendLevel),
            $past(network_cable_detach_mode)), $past(suspPol_r)))
        else $error("suspend pin wrong");
    a_attach_pin: assert property (@(posedge mclk) disable iff (!rstn) // RQ1
        (hsicMode && attachEnable && attachAttempt) |=> attachPin == $past(attachPol_r))
        else $error("attach pin wrong");
    a_attach_det: assert property (@(posedge mclk) disable iff (!rstn) // RQ2
        (attachEnable && network_cable_detach_mode && hsicMode && attachPol_r && !wrAcc) |=> attachPin)
        else $error("attach not driven in detach");
    a_lite_end: assert property (@(posedge mclk) disable iff (!rstn) // RQ9
        (seq_r == SEQ_IDLE && wrAcc && paddr == OFF_HWCFG && pwdata[1:0] == 2'b10)
        |=> seq_r == SEQ_LITE ##[17:17] seq_r == SEQ_IDLE)
        else $error("lite reset length wrong");
    a_lite_phy: assert property (@(posedge mclk) disable iff (!rstn) // RQ10
        seq_r == SEQ_LITE |-> !phyDisconnect && !eepromReq)
        else $error("lite reset touched phy or eeprom");
    a_full_phy: assert property (@(posedge mclk) disable iff (!rstn) // RQ13
        (seq_r == SEQ_FULL && cnt_r == FULL_CYC) |=> !phyDisconnect)
        else $error("phy not reconnected");
    a_ee_flag: assert property (@(posedge mclk) disable iff (!rstn) // RQ8
        evt[IRQ_EE_TO] |=> eeTo_r && sts_r[IRQ_EE_TO])
        else $error("time-out flag not set");
    a_protect: assert property (@(posedge mclk) disable iff (!rstn) // RQ14
        (usbReset && resetProtect && !wrAcc && seq_r != SEQ_FULL) |=> $stable(suspSel_r) && $stable(suspPol_r))
        else $error("protected field changed");
    a_pack_out: assert property (@(posedge mclk) disable iff (!rstn) // RQ6
        (wrAcc && paddr == OFF_HWCFG && seq_r == SEQ_IDLE) |=> multiFramePack == $past(pwdata[POS_PACK]))
        else $error("pack bit not applied");
    a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rstn) // RQ18
        (pready && paddr == OFF_HWCFG) |-> !prdata[2])
        else $error("reserved bit not zero");

    c_lite: cover property (@(posedge mclk) disable iff (!rstn) evt[IRQ_LITE_DONE]);
    c_full: cover property (@(posedge mclk) disable iff (!rstn) evt[IRQ_FULL_DONE]);
    c_eeto: cover property (@(posedge mclk) disable iff (!rstn) evt[IRQ_EE_TO]);
    c_irq: cover property (@(posedge mclk) disable iff (!rstn) $rose(irq));
endmodule
`default_nettype wire

/* core/hw_config_pkg.sv */
// constants for the hardware configuration low-field register block
// assumes a 100 MHz system clock and a 32-bit APB register bus
package hw_config_pkg;
    localparam logic [11:0] OFF_HWCFG = 12'h000;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h004;
    localparam logic [11:0] OFF_IRQ_CLEAR = 12'h008;
    localparam logic [11:0] OFF_IRQ_ENABLE = 12'h00C;
    localparam logic [11:0] OFF_EEPROM_CMD = 12'h010;
    localparam logic [11:0] OFF_STATE_IN = 12'h014;
    // field positions in the configuration word
    localparam int POS_ATTACH_POL = 8;
    localparam int POS_SUSP_SEL = 6;
    localparam int POS_SUSP_POL = 5;
    localparam int POS_PACK = 4;
    localparam int POS_ETC = 3;
    localparam int POS_LITE = 1;
    localparam int POS_FULL = 0;
    // eeprom command register: busy bit, time-out flag
    localparam int POS_EE_BUSY = 31;
    localparam int POS_EE_TO = 9;
    // status bits
    localparam int IRQ_LITE_DONE = 0;
    localparam int IRQ_FULL_DONE = 1;
    localparam int IRQ_EE_TO = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // time-outs
    localparam real CLK_NS = 10.0;
    localparam real EE_TO_LONG_MS = 30.0;
    localparam real EE_TO_SHORT_US = 1.28;
    localparam int EE_TO_LONG_CYC = int'($floor(EE_TO_LONG_MS * 1.0e6 / CLK_NS));
    localparam int EE_TO_SHORT_CYC = int'($floor(EE_TO_SHORT_US * 1.0e3 / CLK_NS));
    // reset sequence lengths
    localparam logic [7:0] LITE_CYC = 8'h10;
    localparam logic [7:0] FULL_CYC = 8'h40;
    localparam logic [2:0] IMG_WORDS = 3'h4;
    typedef enum logic [1:0]
    {
        SEQ_IDLE = 2'b00,
        SEQ_LITE = 2'b01,
        SEQ_LOAD = 2'b10,
        SEQ_FULL = 2'b11
    } seq_t;
endpackage

/* core/image_mem.sv */
// small memory holding the configuration image last loaded from eeprom
// assumes one clock; read data are registered
`timescale 1ns/100ps
`default_nettype none
module image_mem
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // write side
    input wire logic wrEn,
    input wire logic [1:0] wrAddr,
    input wire logic [7:0] wrData,
    // read side
    input wire logic [1:0] rdAddr,
    output logic [7:0] rdData
);
    logic [7:0] mem_r [4];
    logic [7:0] rdData_r;

    // storage; zero image until something was loaded
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 4; i++)
                mem_r[i] <= 8'h00;
            rdData_r <= 8'h00;
        end
        else
        begin
            if (wrEn)
                mem_r[wrAddr] <= wrData;
            rdData_r <= mem_r[rdAddr];
        end
    end
    assign rdData = rdData_r;
endmodule
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for hw_config_low: apb access, pins, soft resets
// assumes the map and timing of the block's note; bench plays eeprom side
`timescale 1ns/100ps
`default_nettype none
module tb;
    import hw_config_pkg::*;
    logic mclk = 1'h0;
    logic rstn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic usbReset = 1'h0;
    logic resetProtect = 1'h0;
    logic hsicMode = 1'h0;
    logic attachEnable = 1'h0;
    logic attachAttempt = 1'h0;
    logic cableDetach = 1'h0;
    logic [3:0] suspendLevel = 4'h0;
    logic eepromPresent = 1'h0;
    logic eepromAck = 1'h0;
    logic [7:0] eepromData = 8'h00;
    logic [31:0] prdata;
    logic pready, pslverr, eepromReq, attachPin, suspendPin;
    logic multiFramePack, phyDisconnect, liteResetOut, irq;
    logic [31:0] v;
    int n_fail = 0;
    int tests_run = 0;

    hw_config_low uut
    (
        .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .usbReset(usbReset), .resetProtect(resetProtect), .hsicMode(hsicMode),
        .attachEnable(attachEnable), .attachAttempt(attachAttempt),
        .network_cable_detach_mode(cableDetach), .suspendLevel(suspendLevel),
        .eepromPresent(eepromPresent), .eepromAck(eepromAck), .eepromData(eepromData),
        .eepromReq(eepromReq), .attachPin(attachPin), .suspendPin(suspendPin),
        .multiFramePack(multiFramePack), .phyDisconnect(phyDisconnect),
        .liteResetOut(liteResetOut), .irq(irq)
    );

    always #5 mclk = ~mclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic err);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'h1 && n < 16);
        if (n == 16)
            n_fail++;
        r = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic err;
        apb(1'h1, a, d, r, err);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic err;
        apb(1'h0, a, 32'h0, r, err);
    endtask

    // values straight after power-on reset
    task automatic t_reset;
        rd(OFF_HWCFG, v);
        check(v, 32'h0);
        rd(OFF_IRQ_STATUS, v);
        check(v, 32'(IRQ_RESET));
        check(32'({attachPin, suspendPin, irq}), 32'h6);
    endtask

    // reserved bit, packing bit, unmapped address, write-only clear
    task automatic t_regs;
        logic [31:0] r;
        logic err;
        wr(OFF_HWCFG, 32'h1FC);
        rd(OFF_HWCFG, v);
        check(v, 32'h1F8);
        check(32'(multiFramePack), 32'h1);
        wr(OFF_HWCFG, 32'h0);
        tick(2);
        check(32'(multiFramePack), 32'h0);
        apb(1'h1, 12'h020, 32'hFFFF_FFFF, r, err);
        check(32'(err), 32'h1);
        apb(1'h0, 12'h020, 32'h0, r, err);
        check({r[30:0], err}, 32'h1);
        rd(OFF_IRQ_CLEAR, v);
        check(v, 32'h0);
    endtask

    // suspend pin over every select code, polarity and level
    task automatic t_susp;
        logic [3:0] lv;
        logic as;
        for (int s = 0; s < 4; s++)
            for (int p = 0; p < 2; p++)
            begin
                wr(OFF_HWCFG, (32'(s) << POS_SUSP_SEL) | (32'(p) << POS_SUSP_POL));
                eepromPresent <= 1'(p);
                for (int k = 0; k < 5; k++)
                begin
                    lv = (k < 4) ? 4'(1 << k) : 4'h0;
                    suspendLevel <= lv;
                    cableDetach <= (k == 4);
                    tick(3);
                    as = lv[2] | (s > 0 && (lv[1] | k == 4)) | (s > 1 && lv[0]) | (s == 3 && lv[3]);
                    check(32'(suspendPin), 32'(p ? as : !as));
                end
            end
        suspendLevel <= 4'h0;
        cableDetach <= 1'h0;
        eepromPresent <= 1'h0;
    endtask

    // attach pin over enable, attempt, detach, polarity and hsic mode
    task automatic t_attach;
        logic [4:0] c;
        logic as;
        for (int i = 0; i < 32; i++)
        begin
            c = 5'(i);
            wr(OFF_HWCFG, 32'(c[4]) << POS_ATTACH_POL);
            hsicMode <= c[3];
            attachEnable <= c[2];
            attachAttempt <= c[1];
            cableDetach <= c[0];
            tick(3);
            as = c[2] & (c[1] | c[0]);
            check(32'(attachPin), 32'((c[3] & c[4]) ? as : !as));
        end
        attachEnable <= 1'h0;
        cableDetach <= 1'h0;
    endtask

    // lite reset: self-clearing bit, pin fields restored unless protected
    task automatic t_lite(input logic prot, input logic [31:0] img);
        int n;
        resetProtect <= prot;
        wr(OFF_HWCFG, 32'h0E0);
        wr(OFF_HWCFG, 32'h0E2);
        tick(1);
        check(32'({liteResetOut, phyDisconnect, eepromReq}), 32'h4);
        rd(OFF_HWCFG, v);
        check(v & 32'h2, 32'h2);
        n = 0;
        while (liteResetOut !== 1'h0 && n < 40)
        begin
            @(posedge mclk);
            n++;
        end
        if (n == 40)
            n_fail++;
        rd(OFF_HWCFG, v);
        check(v & 32'h1E2, prot ? 32'h0E0 : img);
        rd(OFF_IRQ_STATUS, v);
        check(v & 32'h1, 32'h1);
        wr(OFF_IRQ_CLEAR, 32'h1);
        resetProtect <= 1'h0;
    endtask

    // full reset with image load; eeprom silent first to hit the short time-out
    task automatic t_full;
        int n;
        eepromPresent <= 1'h1;
        wr(OFF_IRQ_ENABLE, 32'h7);
        wr(OFF_HWCFG, 32'h008);
        wr(OFF_HWCFG, 32'h009);
        n = 0;
        while (eepromReq !== 1'h1 && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        if (n == 20)
            n_fail++;
        check(32'(phyDisconnect), 32'h1);
        tick(100);
        rd(OFF_EEPROM_CMD, v);
        check(v & 32'h8000_0200, 32'h8000_0000);
        tick(40);
        rd(OFF_EEPROM_CMD, v);
        check(v & 32'h200, 32'h200);
        rd(OFF_IRQ_STATUS, v);
        check(v & 32'h4, 32'h4);
        check(32'(irq), 32'h1);
        wr(OFF_EEPROM_CMD, 32'h200);
        wr(OFF_IRQ_CLEAR, 32'h4);
        rd(OFF_EEPROM_CMD, v);
        check(v & 32'h200, 32'h0);
        // data lines flip between words so stale bytes never look valid
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            eepromAck <= 1'h1;
            eepromData <= (i == 0) ? 8'h1A : 8'(8'h35 * i);
            @(posedge mclk);
            eepromAck <= 1'h0;
            eepromData <= ~eepromData;
        end
        n = 0;
        while (phyDisconnect !== 1'h0 && n < 200)
        begin
            @(posedge mclk);
            n++;
        end
        if (n == 200)
            n_fail++;
        check(32'(eepromReq), 32'h0);
        rd(OFF_HWCFG, v);
        check(v, 32'h1A0);
        rd(OFF_IRQ_STATUS, v);
        check(v & 32'h2, 32'h2);
        wr(OFF_IRQ_CLEAR, 32'h7);
        tick(2);
        check(32'(irq), 32'h0);
        eepromPresent <= 1'h0;
    endtask

    // usb reset restores the loaded image unless protected
    task automatic t_usb(input logic prot);
        resetProtect <= prot;
        wr(OFF_HWCFG, 32'h040);
        usbReset <= 1'h1;
        tick(2);
        usbReset <= 1'h0;
        rd(OFF_HWCFG, v);
        check(v & 32'h1E0, prot ? 32'h040 : 32'h1A0);
        resetProtect <= 1'h0;
    endtask

    // masked event holds status but keeps irq low until enabled
    task automatic t_irq;
        wr(OFF_IRQ_ENABLE, 32'h6);
        wr(OFF_HWCFG, 32'h2);
        tick(30);
        check(32'(irq), 32'h0);
        rd(OFF_IRQ_STATUS, v);
        check(v, 32'h1);
        wr(OFF_IRQ_ENABLE, 32'h7);
        tick(2);
        check(32'(irq), 32'h1);
        wr(OFF_IRQ_CLEAR, 32'h1);
        tick(2);
        check(32'(irq), 32'h0);
    endtask

    // cut a hang short well past the expected run of under a thousand cycles
    initial
    begin
        #200000;
        n_fail++;
        summarize();
    end

    initial
    begin
        repeat (6) @(posedge mclk);
        rstn <= 1'h1;
        t_reset();
        t_regs();
        t_susp();
        t_attach();
        t_lite(1'h0, 32'h0);
        t_lite(1'h1, 32'h0);
        t_full();
        t_lite(1'h0, 32'h1A0);
        t_usb(1'h0);
        t_usb(1'h1);
        t_irq();
        summarize();
    end
endmodule
`default_nettype wire
